// ===== src/pyx_regs.svh
// Constants for the piecewise-linear Y-to-X converter
`ifndef PYX_REGS_SVH
`define PYX_REGS_SVH

// ----
// Format store sizes per controller variant
// ----
`define PYX_FMT_MODULAR 30
`define PYX_FMT_COMPACT 6
`define PYX_PTS_MODULAR 32
`define PYX_PTS_COMPACT 5
`define PYX_PTS_MIN     6'd2

// ----
// Operand limits
// ----
`define PYX_RELAY_LAST  13'd2557
`define PYX_RELAY_SPAN  13'd15
`define PYX_OUT_HI_WORD 40'sd65535
`define PYX_OUT_HI_INT  40'sd32767
`define PYX_OUT_LO_INT  -40'sd32768
`define PYX_OUT_LO_WORD 40'sd0

// ----
// Divider widths
// ----
`define PYX_DIV_NW 38
`define PYX_DIV_DW 20

`endif

// ===== src/pyx_pkg.sv
// Types shared by the converter modules
package pyx_pkg;

    // Data type of a conversion or format
    typedef enum logic [2:0] {
        PYX_DT_WORD  = 3'b000,
        PYX_DT_INT   = 3'b001,
        PYX_DT_DWORD = 3'b010,
        PYX_DT_LONG  = 3'b011,
        PYX_DT_FLOAT = 3'b100
    } pyx_dtype_e;

    // Kind of element named by the source operand
    typedef enum logic [1:0] {
        PYX_SRC_BITS    = 2'b00,
        PYX_SRC_DREG    = 2'b01,
        PYX_SRC_TIMER   = 2'b10,
        PYX_SRC_COUNTER = 2'b11
    } pyx_src_e;

    // Kind of element named by the destination operand
    typedef enum logic [2:0] {
        PYX_DST_OUTPUT  = 3'b000,
        PYX_DST_RELAY   = 3'b001,
        PYX_DST_SHIFT   = 3'b010,
        PYX_DST_TIMER   = 3'b011,
        PYX_DST_COUNTER = 3'b100,
        PYX_DST_DREG    = 3'b101
    } pyx_dst_e;

    // Conversion sequencer states
    typedef enum logic [2:0] {
        PYX_ST_IDLE  = 3'b000,
        PYX_ST_SCAN  = 3'b001,
        PYX_ST_CALC  = 3'b010,
        PYX_ST_DIV   = 3'b011,
        PYX_ST_WRITE = 3'b100
    } pyx_state_e;

endpackage

// ===== src/pyx_seg_match.sv
// Segment span test: key lies between two endpoint keys
`timescale 1ns/1ns
module pyx_seg_match (
    // Key and segment endpoints
    input  wire logic signed [17:0] key_i,
    input  wire logic signed [17:0] k0_i,
    input  wire logic signed [17:0] k1_i,
    // Key inside the closed span
    output logic                    hit_o
);
    // Endpoints may be stored in either order
    wire ascend = (k0_i <= k1_i);
    wire in_up  = (key_i >= k0_i) && (key_i <= k1_i);
    wire in_dn  = (key_i >= k1_i) && (key_i <= k0_i);
    assign hit_o = ascend ? in_up : in_dn;
endmodule

// ===== src/pyx_rdiv.sv
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ns
module pyx_rdiv #(
    parameter int NW = 38,
    parameter int DW = 20
) (
    // Clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          arst_n_i,
    // Request
    input  wire logic          start_i,
    input  wire logic [NW-1:0] num_i,
    input  wire logic [DW-1:0] den_i,
    // Answer
    output logic               done_o,
    output logic [NW-1:0]      quo_o
);
    localparam int CW = $clog2(NW + 1);

    logic [DW:0]   rem;
    logic [DW-1:0] den;
    logic [CW-1:0] cnt;

    // One trial subtraction per step
    wire [DW:0] shifted = {rem[DW-1:0], quo_o[NW-1]};
    wire        fits    = (shifted >= {1'b0, den});
    wire [DW:0] reduced = shifted - {1'b0, den};

    // Iteration; a new start aborts any division in flight
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rem    <= '0;
            den    <= '0;
            cnt    <= '0;
            quo_o  <= '0;
            done_o <= 1'b0;
        end else if (start_i) begin
            rem    <= '0;
            den    <= den_i;
            cnt    <= CW'(NW);
            quo_o  <= num_i;
            done_o <= 1'b0;
        end else if (cnt != '0) begin
            rem    <= fits ? reduced : shifted;
            quo_o  <= {quo_o[NW-2:0], fits};
            cnt    <= cnt - CW'(1);
            done_o <= (cnt == CW'(1));
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule

// ===== src/pyx_converter.sv
// Piecewise-linear coordinate converter with its format store
`timescale 1ns/1ns
`include "pyx_regs.svh"

// Contract
// - While enabled, convert Y operand into X, or X into Y when forward
// - Format selector picks one of 6/30
// - Missing format or type mismatch: error
// - Y range follows word or integer type
// - Backward result written unsigned 0 to 65535
// - Timer/counter source reads current count
// - Timer/counter destination gets preset value
// - Only relays 0 to 2557 as destination
// - Bit devices give sixteen bits per word
// - Word devices use one element
// - Result within half unit of exact
// - Overlapping spans: first segment wins
// - Priority follows stored point order
// - Forward: X span picks the segment
// - Formats hold 2 to 32/5 points
module pyx_converter #(
    parameter bit MODULAR = 1'b1
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    // Format definition from the format-set command
    input  wire logic                  fmt_def_i,
    input  wire logic [4:0]            fmt_def_num_i,
    input  wire pyx_pkg::pyx_dtype_e   fmt_def_type_i,
    input  wire logic [5:0]            fmt_def_npts_i,
    input  wire logic                  pt_wr_i,
    input  wire logic [4:0]            pt_wr_num_i,
    input  wire logic [4:0]            pt_wr_idx_i,
    input  wire logic [15:0]           pt_wr_x_i,
    input  wire logic [15:0]           pt_wr_y_i,
    // Conversion request
    input  wire logic                  enable_i,
    input  wire logic                  dir_fwd_i,
    input  wire pyx_pkg::pyx_dtype_e   conv_type_i,
    input  wire logic [4:0]            format_select_operand_i,
    // Source operand
    input  wire pyx_pkg::pyx_src_e     src_kind_i,
    input  wire logic [15:0]           src_bits_i,
    input  wire logic [15:0]           src_dreg_i,
    input  wire logic [15:0]           timer_current_value_i,
    input  wire logic [15:0]           counter_current_value_i,
    // Destination operand
    input  wire pyx_pkg::pyx_dst_e     dst_kind_i,
    input  wire logic [11:0]           dst_relay_num_i,
    // Result and write strobes
    output logic [15:0]                result_o,
    output logic                       wr_bits_o,
    output logic                       wr_dreg_o,
    output logic                       wr_timer_preset_o,
    output logic                       wr_counter_preset_o,
    // Error report
    input  wire logic                  err_clear_i,
    output logic                       execution_error_relay_o,
    output logic                       err_led_o,
    output logic                       busy_o
);
    import pyx_pkg::*;

    // ----
    // Sizes
    // ----
    localparam int NFMT  = MODULAR ? `PYX_FMT_MODULAR : `PYX_FMT_COMPACT;
    localparam int NPTS  = MODULAR ? `PYX_PTS_MODULAR : `PYX_PTS_COMPACT;
    localparam int DEPTH = NFMT * NPTS;
    localparam int NW    = `PYX_DIV_NW;
    localparam int DW    = `PYX_DIV_DW;

    // ----
    // Format store
    // ----
    logic [15:0]      pt_x [DEPTH];
    logic [15:0]      pt_y [DEPTH];
    logic [NFMT-1:0]  fmt_valid;
    pyx_dtype_e       fmt_type [NFMT];
    logic [5:0]       fmt_npts [NFMT];

    // Definition checks: count bounds and accepted types
    wire def_num_ok  = (32'(fmt_def_num_i) < NFMT);
    wire def_cnt_ok  = (fmt_def_npts_i >= `PYX_PTS_MIN)
                     && (32'(fmt_def_npts_i) <= NPTS);
    wire def_type_ok = (fmt_def_type_i == PYX_DT_WORD)
                     || (fmt_def_type_i == PYX_DT_INT);
    wire pt_ok       = (32'(pt_wr_num_i) < NFMT) && (32'(pt_wr_idx_i) < NPTS);
    wire [9:0] pt_addr = 10'(10'(pt_wr_num_i) * 10'(NPTS) + 10'(pt_wr_idx_i));

    // Point storage keeps point index order, which fixes segment priority
    always_ff @(posedge ref_clk_i) begin
        if (pt_wr_i && pt_ok) begin
            pt_x[pt_addr] <= pt_wr_x_i;
            pt_y[pt_addr] <= pt_wr_y_i;
        end
    end

    // Format headers; a bad definition leaves the format undefined
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fmt_valid <= '0;
            for (int i = 0; i < NFMT; i++) begin
                fmt_type[i] <= PYX_DT_WORD;
                fmt_npts[i] <= '0;
            end
        end else if (fmt_def_i && def_num_ok) begin
            fmt_valid[fmt_def_num_i] <= def_cnt_ok && def_type_ok;
            fmt_type[fmt_def_num_i]  <= fmt_def_type_i;
            fmt_npts[fmt_def_num_i]  <= fmt_def_npts_i;
        end
    end

    // ----
    // Request checks and operand fetch
    // ----
    pyx_state_e state;
    pyx_state_e next_state;

    wire sel_ok   = (32'(format_select_operand_i) < NFMT);
    wire fmt_ok   = sel_ok && fmt_valid[format_select_operand_i];
    wire type_ok  = (conv_type_i == PYX_DT_WORD)
                  || (conv_type_i == PYX_DT_INT);
    wire match_ok = fmt_ok && (fmt_type[format_select_operand_i] == conv_type_i);
    // Relay destination takes sixteen relays, all ordinary ones
    wire [12:0] relay_last = 13'(dst_relay_num_i) + `PYX_RELAY_SPAN;
    wire dst_ok   = (dst_kind_i != PYX_DST_RELAY)
                  || (relay_last <= `PYX_RELAY_LAST);
    wire chk_ok   = match_ok && type_ok && dst_ok;
    wire err_set  = (state == PYX_ST_IDLE) && enable_i && !chk_ok;
    wire start    = (state == PYX_ST_IDLE) && enable_i && chk_ok;

    // Source word: bit devices pack sixteen bits, word devices one element
    wire [15:0] src_word =
        (src_kind_i == PYX_SRC_BITS)  ? src_bits_i :
        (src_kind_i == PYX_SRC_TIMER) ? timer_current_value_i :
        (src_kind_i == PYX_SRC_COUNTER) ? counter_current_value_i :
        src_dreg_i;
    wire in_int = (conv_type_i == PYX_DT_INT);
    // Backward key is Y, signed in integer mode; forward key X is unsigned
    wire signed [17:0] src_key = (!dir_fwd_i && in_int)
                               ? {{2{src_word[15]}}, src_word}
                               : {2'b00, src_word};

    // Request snapshot held for the whole conversion
    logic              cur_fwd;
    logic              cur_int;
    logic [4:0]        cur_sel;
    logic [5:0]        cur_npts;
    logic signed [17:0] cur_key;
    pyx_dst_e          cur_dst;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_fwd  <= 1'b0;
            cur_int  <= 1'b0;
            cur_sel  <= '0;
            cur_npts <= '0;
            cur_key  <= '0;
            cur_dst  <= PYX_DST_DREG;
        end else if (start) begin
            cur_fwd  <= dir_fwd_i;
            cur_int  <= in_int;
            cur_sel  <= format_select_operand_i;
            cur_npts <= fmt_npts[format_select_operand_i];
            cur_key  <= src_key;
            cur_dst  <= dst_kind_i;
        end
    end

    // ----
    // Segment search in stored order
    // ----
    logic [4:0] seg_idx;
    wire  [9:0] addr_a = 10'(10'(cur_sel) * 10'(NPTS) + 10'(seg_idx));
    wire  [9:0] addr_b = 10'(addr_a + 10'd1);
    wire  [15:0] xa = pt_x[addr_a];
    wire  [15:0] xb = pt_x[addr_b];
    wire  [15:0] ya = pt_y[addr_a];
    wire  [15:0] yb = pt_y[addr_b];
    wire signed [17:0] xa_s = {2'b00, xa};
    wire signed [17:0] xb_s = {2'b00, xb};
    wire signed [17:0] ya_s = cur_int ? {{2{ya[15]}}, ya} : {2'b00, ya};
    wire signed [17:0] yb_s = cur_int ? {{2{yb[15]}}, yb} : {2'b00, yb};
    // Forward searches X spans, backward searches Y spans
    wire signed [17:0] ka = cur_fwd ? xa_s : ya_s;
    wire signed [17:0] kb = cur_fwd ? xb_s : yb_s;
    wire signed [17:0] va = cur_fwd ? ya_s : xa_s;
    wire signed [17:0] vb = cur_fwd ? yb_s : xb_s;
    logic seg_hit;

    pyx_seg_match u_match (
        .key_i (cur_key),
        .k0_i  (ka),
        .k1_i  (kb),
        .hit_o (seg_hit)
    );

    // Out-of-range keys extrapolate along the last segment
    wire last_seg = ((6'(seg_idx) + 6'd2) >= cur_npts);
    wire seg_take = (state == PYX_ST_SCAN) && (seg_hit || last_seg);

    logic signed [17:0] seg_k0;
    logic signed [17:0] seg_k1;
    logic signed [17:0] seg_v0;
    logic signed [17:0] seg_v1;

    // Walk segments from the first pair; first hit stops the walk
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seg_idx <= '0;
            seg_k0  <= '0;
            seg_k1  <= '0;
            seg_v0  <= '0;
            seg_v1  <= '0;
        end else if (start) begin
            seg_idx <= '0;
        end else if (seg_take) begin
            seg_k0  <= ka;
            seg_k1  <= kb;
            seg_v0  <= va;
            seg_v1  <= vb;
        end else if (state == PYX_ST_SCAN) begin
            seg_idx <= seg_idx + 5'd1;
        end
    end

    // ----
    // Interpolation with rounding to nearest
    // ----
    wire signed [18:0] dk   = 19'(seg_k1) - 19'(seg_k0);
    wire signed [18:0] dkey = 19'(cur_key) - 19'(seg_k0);
    wire signed [18:0] dv   = 19'(seg_v1) - 19'(seg_v0);
    wire signed [37:0] prod = 38'(dkey) * 38'(dv);
    wire        flat_now  = (dk == '0);
    wire        neg_now   = prod[37] ^ dk[18];
    wire [37:0] abs_prod  = prod[37] ? 38'(-prod) : 38'(prod);
    wire [18:0] abs_dk    = dk[18] ? 19'(-dk) : 19'(dk);
    // Adding half the divisor before truncation rounds to nearest
    wire [NW-1:0] div_num = {abs_prod[36:0], 1'b0} + NW'(abs_dk);
    wire [DW-1:0] div_den = {abs_dk, 1'b0};
    wire          div_go  = (state == PYX_ST_CALC) && !flat_now;
    logic          div_done;
    logic [NW-1:0] div_quo;

    pyx_rdiv #(
        .NW (NW),
        .DW (DW)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (div_go),
        .num_i     (div_num),
        .den_i     (div_den),
        .done_o    (div_done),
        .quo_o     (div_quo)
    );

    // Sign and flat-segment flags held through the division
    logic neg_r;
    logic flat_r;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            neg_r  <= 1'b0;
            flat_r <= 1'b0;
        end else if (state == PYX_ST_CALC) begin
            neg_r  <= neg_now;
            flat_r <= flat_now;
        end
    end

    // Sum and clamp to the destination range
    wire signed [39:0] q_mag = flat_r ? 40'sd0 : $signed({2'b00, div_quo});
    wire signed [39:0] q_s   = neg_r ? -q_mag : q_mag;
    wire signed [39:0] sum   = 40'(seg_v0) + q_s;
    wire               out_signed = cur_fwd && cur_int;
    wire signed [39:0] lim_lo = out_signed ? `PYX_OUT_LO_INT : `PYX_OUT_LO_WORD;
    wire signed [39:0] lim_hi = out_signed ? `PYX_OUT_HI_INT : `PYX_OUT_HI_WORD;
    wire signed [39:0] clamped = (sum < lim_lo) ? lim_lo :
                                 (sum > lim_hi) ? lim_hi : sum;

    // ----
    // Sequencer
    // ----
    always_comb begin
        next_state = state;
        case (state)
            PYX_ST_IDLE:  if (start) next_state = PYX_ST_SCAN;
            PYX_ST_SCAN:  if (seg_take) next_state = PYX_ST_CALC;
            PYX_ST_CALC:  next_state = flat_now ? PYX_ST_WRITE : PYX_ST_DIV;
            PYX_ST_DIV:   if (div_done) next_state = PYX_ST_WRITE;
            PYX_ST_WRITE: next_state = PYX_ST_IDLE;
            default:      next_state = PYX_ST_IDLE;
        endcase
    end

    // State register and busy flag
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state  <= PYX_ST_IDLE;
            busy_o <= 1'b0;
        end else begin
            state  <= next_state;
            busy_o <= (next_state != PYX_ST_IDLE);
        end
    end

    // ----
    // Result write and error report
    // ----
    wire do_write = (state == PYX_ST_WRITE);
    wire is_bits  = (cur_dst == PYX_DST_OUTPUT) || (cur_dst == PYX_DST_RELAY)
                  || (cur_dst == PYX_DST_SHIFT);

    // Result and its strobe appear together, one cycle after WRITE
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_o            <= '0;
            wr_bits_o           <= 1'b0;
            wr_dreg_o           <= 1'b0;
            wr_timer_preset_o   <= 1'b0;
            wr_counter_preset_o <= 1'b0;
        end else begin
            if (do_write) begin
                result_o <= clamped[15:0];
            end
            wr_bits_o           <= do_write && is_bits;
            wr_dreg_o           <= do_write && (cur_dst == PYX_DST_DREG);
            wr_timer_preset_o   <= do_write && (cur_dst == PYX_DST_TIMER);
            wr_counter_preset_o <= do_write && (cur_dst == PYX_DST_COUNTER);
        end
    end

    // Sticky error: a new error in the clear cycle wins over the clear
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            execution_error_relay_o <= 1'b0;
            err_led_o               <= 1'b0;
        end else if (err_set) begin
            execution_error_relay_o <= 1'b1;
            err_led_o               <= 1'b1;
        end else if (err_clear_i) begin
            execution_error_relay_o <= 1'b0;
            err_led_o               <= 1'b0;
        end
    end
endmodule

// ===== tb/pyx_checker.sv
// Port assertions for the Y-to-X converter
`timescale 1ns/1ns
module pyx_checker #(
    parameter bit MODULAR = 1'b1
) (
    // Clock, reset and request
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic                enable_i,
    input  wire pyx_pkg::pyx_dtype_e conv_type_i,
    input  wire logic [4:0]          format_select_operand_i,
    input  wire pyx_pkg::pyx_dst_e   dst_kind_i,
    input  wire logic [11:0]         dst_relay_num_i,
    // Strobes and status
    input  wire logic                wr_bits_o,
    input  wire logic                wr_dreg_o,
    input  wire logic                wr_timer_preset_o,
    input  wire logic                wr_counter_preset_o,
    input  wire logic                err_clear_i,
    input  wire logic                execution_error_relay_o,
    input  wire logic                err_led_o,
    input  wire logic                busy_o
);
    import pyx_pkg::*;
    localparam int NFMT = MODULAR ? 30 : 6;
    // Take and refusal decode; undefined formats are invisible here
    wire       take = enable_i && !busy_o;
    wire [3:0] stb  = {wr_bits_o, wr_dreg_o, wr_timer_preset_o, wr_counter_preset_o};
    wire       bad  = (format_select_operand_i >= NFMT) ||
                      !(conv_type_i inside {PYX_DT_WORD, PYX_DT_INT}) ||
                      (dst_kind_i == PYX_DST_RELAY && dst_relay_num_i > 12'd2542);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_led_follows: assert property (err_led_o == execution_error_relay_o)
        else $error("error lamp differs from error relay");
    a_refuse_flags: assert property (take && bad |=> execution_error_relay_o && !busy_o)
        else $error("refused take did not flag");
    a_err_sticky: assert property (execution_error_relay_o && !err_clear_i |=> execution_error_relay_o)
        else $error("error relay dropped without clear");
    a_err_clears: assert property (execution_error_relay_o && err_clear_i && !enable_i |=> !execution_error_relay_o)
        else $error("error relay ignored clear");
    a_one_strobe: assert property ($onehot0(stb))
        else $error("more than one write strobe");
    a_stb_ends_busy: assert property (|stb |-> !busy_o && $past(busy_o))
        else $error("strobe not at end of busy");
    a_busy_bounded: assert property ($rose(busy_o) |-> ##[2:120] !busy_o)
        else $error("conversion did not finish");
    a_timer_dest: assert property (wr_timer_preset_o |-> dst_kind_i == PYX_DST_TIMER)
        else $error("preset strobe for wrong destination");
    a_good_starts: assert property (take && !bad && !execution_error_relay_o |=> busy_o || execution_error_relay_o)
        else $error("valid take neither ran nor flagged");
    c_conv: cover property (take && !bad);
    c_timer: cover property (wr_timer_preset_o);
    c_err: cover property ($rose(execution_error_relay_o));
endmodule
bind pyx_converter pyx_checker #(.MODULAR(MODULAR)) u_chk (.*);

// ===== tb/pyx_exec_model.sv
// Scan executor model that loads point formats
`timescale 1ns/1ns
module pyx_exec_model (
    // Clock
    input  wire logic               ref_clk_i,
    // Format store writes
    output logic                    fmt_def_o,
    output logic [4:0]              fmt_num_o,
    output pyx_pkg::pyx_dtype_e     fmt_type_o,
    output logic [5:0]              fmt_npts_o,
    output logic                    pt_wr_o,
    output logic [4:0]              pt_idx_o,
    output logic [15:0]             pt_x_o,
    output logic [15:0]             pt_y_o
);
    import pyx_pkg::*;
    initial begin
        fmt_def_o = 1'b0;
        pt_wr_o   = 1'b0;
    end
    // One point per strobe; lines go junk when released
    task automatic pt(input logic [4:0] i, input logic [15:0] x, y);
        @(negedge ref_clk_i);
        pt_idx_o = i;
        pt_x_o   = x;
        pt_y_o   = y;
        pt_wr_o  = 1'b1;
        @(negedge ref_clk_i);
        pt_wr_o  = 1'b0;
        pt_x_o   = ~x;
        pt_y_o   = ~y;
    endtask
    // Definition, then points in stored order
    task automatic fmt(input logic [4:0] n, input pyx_dtype_e t, input logic [5:0] np,
                       input logic [15:0] x0, y0, x1, y1, x2, y2);
        @(negedge ref_clk_i);
        fmt_num_o  = n;
        fmt_type_o = t;
        fmt_npts_o = np;
        fmt_def_o  = 1'b1;
        @(negedge ref_clk_i);
        fmt_def_o  = 1'b0;
        pt(5'd0, x0, y0);
        pt(5'd1, x1, y1);
        pt(5'd2, x2, y2);
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the Y-to-X converter
`timescale 1ns/1ns
module tb;
    import pyx_pkg::*;
    typedef struct packed {
        logic fwd; logic [4:0] fmt; pyx_dtype_e typ; pyx_src_e sk; logic [15:0] sv;
        pyx_dst_e dk; logic [11:0] rl; logic [15:0] ex; logic err;
    } pyx_row_s;
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, enable_i = 1'b0, dir_fwd_i = 1'b0;
    logic err_clear_i = 1'b0;
    pyx_dtype_e conv_type_i = PYX_DT_WORD;
    pyx_src_e src_kind_i = PYX_SRC_DREG;
    pyx_dst_e dst_kind_i = PYX_DST_DREG;
    logic [4:0] format_select_operand_i = 5'h0, fmt_def_num_i, pt_wr_idx_i;
    logic [15:0] src_bits_i = 16'h0, src_dreg_i = 16'h0, timer_current_value_i = 16'h0;
    logic [15:0] counter_current_value_i = 16'h0, pt_wr_x_i, pt_wr_y_i, result_o;
    logic [11:0] dst_relay_num_i = 12'h0;
    logic [5:0] fmt_def_npts_i;
    pyx_dtype_e fmt_def_type_i;
    logic fmt_def_i, pt_wr_i, wr_bits_o, wr_dreg_o, wr_timer_preset_o, wr_counter_preset_o;
    logic execution_error_relay_o, err_led_o, busy_o;
    wire [3:0] stb = {wr_bits_o, wr_dreg_o, wr_timer_preset_o, wr_counter_preset_o};
    int n_fail = 0, num_checks = 0;
    pyx_row_s rows[16];
    always #2 ref_clk_i = ~ref_clk_i;
    pyx_exec_model m_exec (.ref_clk_i, .fmt_def_o(fmt_def_i), .fmt_num_o(fmt_def_num_i),
        .fmt_type_o(fmt_def_type_i), .fmt_npts_o(fmt_def_npts_i), .pt_wr_o(pt_wr_i),
        .pt_idx_o(pt_wr_idx_i), .pt_x_o(pt_wr_x_i), .pt_y_o(pt_wr_y_i));
    pyx_converter #(.MODULAR(1'b1)) i_pyx_converter (.ref_clk_i, .arst_n_i, .fmt_def_i,
        .fmt_def_num_i, .fmt_def_type_i, .fmt_def_npts_i, .pt_wr_i, .pt_wr_num_i(fmt_def_num_i),
        .pt_wr_idx_i, .pt_wr_x_i, .pt_wr_y_i, .enable_i, .dir_fwd_i, .conv_type_i,
        .format_select_operand_i, .src_kind_i, .src_bits_i, .src_dreg_i, .timer_current_value_i,
        .counter_current_value_i, .dst_kind_i, .dst_relay_num_i, .result_o, .wr_bits_o,
        .wr_dreg_o, .wr_timer_preset_o, .wr_counter_preset_o, .err_clear_i,
        .execution_error_relay_o, .err_led_o, .busy_o);
    // ----
    // Compare, report and run helpers
    // ----
    task automatic chk(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Unselected sources carry the inverse so a wrong pick shows
    task automatic run(input pyx_row_s r);
        int k;
        @(negedge ref_clk_i);
        {dir_fwd_i, conv_type_i, format_select_operand_i} = {r.fwd, r.typ, r.fmt};
        {src_kind_i, dst_kind_i, dst_relay_num_i} = {r.sk, r.dk, r.rl};
        src_bits_i = (r.sk == PYX_SRC_BITS) ? r.sv : ~r.sv;
        src_dreg_i = (r.sk == PYX_SRC_DREG) ? r.sv : ~r.sv;
        timer_current_value_i = (r.sk == PYX_SRC_TIMER) ? r.sv : ~r.sv;
        counter_current_value_i = (r.sk == PYX_SRC_COUNTER) ? r.sv : ~r.sv;
        enable_i = 1'b1;
        for (k = 0; k < 150 && stb === 4'h0 && execution_error_relay_o !== 1'b1; k++)
            @(negedge ref_clk_i);
        if (k == 150) begin
            n_fail++;
            wrap_up();
        end
        enable_i = 1'b0;
        chk("error", {15'h0, r.err}, {15'h0, execution_error_relay_o});
        chk("lamp", {15'h0, r.err}, {15'h0, err_led_o});
        if (!r.err) chk("result", r.ex, result_o);
        if (!r.err) chk("strobe", r.dk == PYX_DST_DREG ? 16'h4 : r.dk == PYX_DST_TIMER ? 16'h2 :
            r.dk == PYX_DST_COUNTER ? 16'h1 : 16'h8, {12'h0, stb});
        for (k = 0; k < 150 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
        if (k == 150) n_fail++;
        err_clear_i = 1'b1;
        @(negedge ref_clk_i);
        err_clear_i = 1'b0;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        // Columns: fwd fmt type src_kind value dst_kind relay expected error
        rows[0]  = {1'b0, 5'd0, 3'd0, 2'd1, 16'd2500, 3'd5, 12'd0, 16'd5000, 1'b0};
        rows[1]  = {1'b0, 5'd1, 3'd0, 2'd3, 16'd40, 3'd5, 12'd0, 16'd60, 1'b0};
        rows[2]  = {1'b0, 5'd2, 3'd0, 2'd1, 16'd40, 3'd4, 12'd0, 16'd180, 1'b0};
        rows[3]  = {1'b0, 5'd3, 3'd1, 2'd2, 16'hfe0c, 3'd3, 12'd0, 16'd500, 1'b0};
        rows[4]  = {1'b0, 5'd3, 3'd1, 2'd1, 16'hf830, 3'd5, 12'd0, 16'd0, 1'b0};
        rows[5]  = {1'b0, 5'd0, 3'd0, 2'd1, 16'h9c40, 3'd5, 12'd0, 16'hffff, 1'b0};
        rows[6]  = {1'b0, 5'd4, 3'd0, 2'd1, 16'd1, 3'd5, 12'd0, 16'd3, 1'b0};
        rows[7]  = {1'b0, 5'd4, 3'd0, 2'd1, 16'd2, 3'd0, 12'd0, 16'd7, 1'b0};
        rows[8]  = {1'b0, 5'd0, 3'd0, 2'd0, 16'd1000, 3'd1, 12'd2542, 16'd2000, 1'b0};
        rows[9]  = {1'b1, 5'd1, 3'd0, 2'd3, 16'd250, 3'd2, 12'd0, 16'd75, 1'b0};
        rows[10] = {1'b0, 5'd5, 3'd0, 2'd1, 16'd1, 3'd5, 12'd0, 16'd0, 1'b1};
        rows[11] = {1'b0, 5'd0, 3'd1, 2'd1, 16'd1, 3'd5, 12'd0, 16'd0, 1'b1};
        rows[12] = {1'b0, 5'd0, 3'd2, 2'd1, 16'd1, 3'd5, 12'd0, 16'd0, 1'b1};
        rows[13] = {1'b0, 5'd0, 3'd0, 2'd1, 16'd1, 3'd1, 12'd2543, 16'd0, 1'b1};
        rows[14] = {1'b0, 5'd30, 3'd0, 2'd1, 16'd1, 3'd5, 12'd0, 16'd0, 1'b1};
        rows[15] = {1'b0, 5'd6, 3'd0, 2'd1, 16'd1, 3'd5, 12'd0, 16'd0, 1'b1};
        repeat (5) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        m_exec.fmt(5'd0, PYX_DT_WORD, 6'd2, 16'd0, 16'd0, 16'd8000, 16'd4000, 16'd0, 16'd0);
        m_exec.fmt(5'd1, PYX_DT_WORD, 6'd3, 16'd0, 16'd100, 16'd100, 16'd0, 16'd300, 16'd100);
        m_exec.fmt(5'd2, PYX_DT_WORD, 6'd3, 16'd300, 16'd100, 16'd100, 16'd0, 16'd0, 16'd100);
        m_exec.fmt(5'd3, PYX_DT_INT, 6'd2, 16'd0, 16'hfc18, 16'd2000, 16'd1000, 16'd0, 16'd0);
        m_exec.fmt(5'd4, PYX_DT_WORD, 6'd2, 16'd0, 16'd0, 16'd10, 16'd3, 16'd0, 16'd0);
        m_exec.fmt(5'd6, PYX_DT_WORD, 6'd1, 16'd0, 16'd0, 16'd9, 16'd9, 16'd0, 16'd0);
        for (int i = 0; i < 16; i++) run(rows[i]);
        // Reset in mid conversion wipes outputs and the format headers; stored points are kept
        @(negedge ref_clk_i);
        format_select_operand_i = 5'd0;
        enable_i = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        arst_n_i = 1'b0;
        enable_i = 1'b0;
        @(negedge ref_clk_i);
        chk("reset", 16'h0, {result_o[14:0], busy_o | execution_error_relay_o | (|stb)});
        arst_n_i = 1'b1;
        run(rows[10]);
        run({1'b0, 5'd0, 3'd0, 2'd1, 16'd2500, 3'd5, 12'd0, 16'd0, 1'b1});
        wrap_up();
    end
endmodule
